/* File: shared/pwm_params.svh */
// offsets, field positions, reset values and counts of the pulse-width modulator
// ----------------------------------------------------------------------------
// Contract
// - eight-bit duty; count clock is the oscillator or oscillator divided by two
// - undivided source: period is 255 times (n+1) oscillator cycles
// - high time is period times m/255, that is m(n+1) count clocks
// - enable bit 0 of control initialises output; pulses begin high
// - duty or prescaler writes while running apply from the next period
// - source select zero: low lead-in of (n+1)/2 oscillator cycles first
// - source select one: low lead-in of (n+1) oscillator cycles first
// - pulse output shares its pin with one general port bit
// ----------------------------------------------------------------------------
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define PWM_ADDR_W      12
`define PWM_OFS_CTRL    12'h000
`define PWM_OFS_PRESC   12'h004
`define PWM_OFS_DUTY    12'h008
`define PWM_OFS_PORT    12'h00C
`define PWM_OFS_STATUS  12'h010

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PWM_CTRL_EN     0
`define PWM_CTRL_SRC    1
`define PWM_PORT_VAL    0
`define PWM_PORT_DIR    1
`define PWM_PORT_PIN    2

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define PWM_RST_PRESC   8'h00
`define PWM_RST_DUTY    8'h00
`define PWM_SLOT_LAST   8'hFE

`endif

/* File: shared/pwm_pkg.sv */
// types of the pulse-width modulator
package pwm_pkg;

	typedef enum logic [2:0] {
		PW_IDLE = 3'b001,
		PW_LEAD = 3'b010,
		PW_RUN  = 3'b100
	} pwm_phase_type;

	typedef struct packed {
		pwm_phase_type phase;
		logic          div_tog;
		logic [7:0]    pre_cnt;
		logic [7:0]    slot_cnt;
		logic [8:0]    lead_cnt;
		logic [7:0]    n_act;
		logic [7:0]    m_act;
		logic          sel_act;
		logic          level;
	} pwm_core_state_type;

	typedef struct packed {
		logic          ctrl_en;
		logic          ctrl_src;
		logic [7:0]    presc;
		logic [7:0]    duty;
		logic          port_val;
		logic          port_dir;
		logic [1:0]    pin_sync;
		logic          pin_o;
		logic          pin_oe;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
	} pwm_top_state_type;

endpackage

/* File: logic/pwm_core.sv */
// prescaler, slot counter and lead-in sequencer of the modulator
`timescale 1ns/10ps
`default_nettype none
`include "pwm_params.svh"

module pwm_core (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// settings
	input  wire logic       enable,
	input  wire logic       src_sel,
	input  wire logic [7:0] prescale,
	input  wire logic [7:0] duty,
	// state
	output logic            level,
	output logic            in_lead,
	output logic            running
);

	localparam pwm_pkg::pwm_core_state_type CORE_RST = '{
		phase: pwm_pkg::PW_IDLE, div_tog: 1'b0, pre_cnt: 8'h00, slot_cnt: 8'h00,
		lead_cnt: 9'h000, n_act: 8'h00, m_act: 8'h00, sel_act: 1'b0, level: 1'b0};

	pwm_pkg::pwm_core_state_type st_reg;
	pwm_pkg::pwm_core_state_type st_next;
	logic       tick;
	logic [8:0] lead_len;

	// ------------------------------------------------------------------------
	// count clock and lead-in length
	// ------------------------------------------------------------------------
	assign tick = st_reg.sel_act ? st_reg.div_tog : 1'b1;
	// half a count step is not whole at select zero with even n: rounded up
	assign lead_len = src_sel ? ({1'b0, prescale} + 9'h001)
		: (({1'b0, prescale} + 9'h002) >> 1);

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg.phase)
			pwm_pkg::PW_IDLE: begin
				st_next.level = 1'b0;
				st_next.div_tog = 1'b0;
				// clear leftovers of a cut run: a smaller new n would leave pre_cnt above it
				st_next.pre_cnt = 8'h00;
				st_next.slot_cnt = 8'h00;
				if (enable) begin
					st_next.n_act = prescale;
					st_next.m_act = duty;
					st_next.sel_act = src_sel;
					st_next.lead_cnt = lead_len;
					st_next.phase = pwm_pkg::PW_LEAD;
				end
			end
			pwm_pkg::PW_LEAD: begin
				if (st_reg.lead_cnt == 9'h001) begin
					st_next.phase = pwm_pkg::PW_RUN;
					st_next.pre_cnt = 8'h00;
					st_next.slot_cnt = 8'h00;
					st_next.level = (st_reg.m_act != 8'h00);
				end else begin
					st_next.lead_cnt = st_reg.lead_cnt - 9'h001;
				end
			end
			pwm_pkg::PW_RUN: begin
				st_next.div_tog = ~st_reg.div_tog;
				if (tick) begin
					if (st_reg.pre_cnt == st_reg.n_act) begin
						st_next.pre_cnt = 8'h00;
						if (st_reg.slot_cnt == `PWM_SLOT_LAST) begin
							// new settings only at the period boundary
							st_next.slot_cnt = 8'h00;
							st_next.n_act = prescale;
							st_next.m_act = duty;
							st_next.sel_act = src_sel;
							st_next.level = (duty != 8'h00);
						end else begin
							st_next.slot_cnt = st_reg.slot_cnt + 8'h01;
							st_next.level = ((st_reg.slot_cnt + 8'h01) < st_reg.m_act);
						end
					end else begin
						st_next.pre_cnt = st_reg.pre_cnt + 8'h01;
					end
				end
			end
			default: st_next = CORE_RST;
		endcase
		if (!enable) begin
			st_next.phase = pwm_pkg::PW_IDLE;
			st_next.level = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= CORE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.level;
	assign in_lead = (st_reg.phase == pwm_pkg::PW_LEAD);
	assign running = (st_reg.phase == pwm_pkg::PW_RUN);

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	sequence s_lead_start;
		$rose(st_reg.phase == pwm_pkg::PW_LEAD);
	endsequence

	property p_lead_len_div2;
		@(posedge pclk) disable iff (!presetn)
		s_lead_start and st_reg.sel_act |-> st_reg.lead_cnt == {1'b0, st_reg.n_act} + 9'h001;
	endproperty
	a_lead_len_div2: assert property (p_lead_len_div2) else $error("lead-in length wrong, divided");

	property p_lead_len_full;
		@(posedge pclk) disable iff (!presetn)
		s_lead_start and !st_reg.sel_act
			|-> st_reg.lead_cnt == (({1'b0, st_reg.n_act} + 9'h002) >> 1);
	endproperty
	a_lead_len_full: assert property (p_lead_len_full) else $error("lead-in length wrong, full");

	property p_lead_low;
		@(posedge pclk) disable iff (!presetn)
		st_reg.phase == pwm_pkg::PW_LEAD |-> !level;
	endproperty
	a_lead_low: assert property (p_lead_low) else $error("output high during lead-in");

	property p_start_high;
		@(posedge pclk) disable iff (!presetn)
		(in_lead && st_reg.lead_cnt == 9'h001 && st_reg.m_act != 8'h00 && enable) |=> running && level;
	endproperty
	a_start_high: assert property (p_start_high) else $error("first pulse does not start high");

	property p_duty_level;
		@(posedge pclk) disable iff (!presetn)
		running |-> level == (st_reg.slot_cnt < st_reg.m_act);
	endproperty
	a_duty_level: assert property (p_duty_level) else $error("level does not match duty");

	property p_hold_mid_period;
		@(posedge pclk) disable iff (!presetn)
		(running && enable && !(tick && st_reg.pre_cnt == st_reg.n_act
			&& st_reg.slot_cnt == `PWM_SLOT_LAST)) |=> $stable(st_reg.n_act) && $stable(st_reg.m_act);
	endproperty
	a_hold_mid_period: assert property (p_hold_mid_period) else $error("settings changed mid period");

	property p_div_tick;
		@(posedge pclk) disable iff (!presetn)
		(running && enable && st_reg.sel_act && tick && !(st_reg.slot_cnt == `PWM_SLOT_LAST))
			|=> !tick ##1 tick;
	endproperty
	a_div_tick: assert property (p_div_tick) else $error("divided count clock wrong");

	property p_slot_range;
		@(posedge pclk) disable iff (!presetn)
		st_reg.slot_cnt <= `PWM_SLOT_LAST && st_reg.pre_cnt <= st_reg.n_act;
	endproperty
	a_slot_range: assert property (p_slot_range) else $error("period counters out of range");

endmodule // pwm_core

`default_nettype wire

/* File: logic/pwm_prescaled.sv */
// apb register file and shared pin of the pulse-width modulator
`timescale 1ns/10ps
`default_nettype none
`include "pwm_params.svh"

module pwm_prescaled (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`PWM_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic [31:0]                 prdata,
	// shared pin
	input  wire logic                   shared_port_pin_i,
	output logic                        shared_port_pin_o,
	output logic                        shared_port_pin_oe
);

	localparam pwm_pkg::pwm_top_state_type TOP_RST = '{
		ctrl_en: 1'b0, ctrl_src: 1'b0, presc: `PWM_RST_PRESC, duty: `PWM_RST_DUTY,
		port_val: 1'b0, port_dir: 1'b0, pin_sync: 2'b00, pin_o: 1'b0, pin_oe: 1'b0,
		pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};

	pwm_pkg::pwm_top_state_type st_reg;
	pwm_pkg::pwm_top_state_type st_next;
	logic core_level;
	logic core_lead;
	logic core_run;
	logic setup_seen;
	logic access_done;

	// ------------------------------------------------------------------------
	// modulator
	// ------------------------------------------------------------------------
	pwm_core u_core (
		.pclk     (pclk),
		.presetn  (presetn),
		.enable   (st_reg.ctrl_en),
		.src_sel  (st_reg.ctrl_src),
		.prescale (st_reg.presc),
		.duty     (st_reg.duty),
		.level    (core_level),
		.in_lead  (core_lead),
		.running  (core_run)
	);

	// ------------------------------------------------------------------------
	// bus, registers and pin
	// ------------------------------------------------------------------------
	// one wait state: decode in the first access cycle, answer in the second
	assign setup_seen = psel && penable && !st_reg.pready;
	assign access_done = psel && penable && st_reg.pready;

	always_comb begin
		st_next = st_reg;
		st_next.pready = setup_seen;
		st_next.pslverr = 1'b0;
		st_next.pin_sync = {st_reg.pin_sync[0], shared_port_pin_i};
		if (setup_seen) begin
			st_next.prdata = 32'h0000_0000;
			case (paddr)
				`PWM_OFS_CTRL: begin
					st_next.prdata[`PWM_CTRL_EN] = st_reg.ctrl_en;
					st_next.prdata[`PWM_CTRL_SRC] = st_reg.ctrl_src;
				end
				`PWM_OFS_PRESC: st_next.prdata[7:0] = st_reg.presc;
				`PWM_OFS_DUTY: st_next.prdata[7:0] = st_reg.duty;
				`PWM_OFS_PORT: begin
					st_next.prdata[`PWM_PORT_VAL] = st_reg.port_val;
					st_next.prdata[`PWM_PORT_DIR] = st_reg.port_dir;
					st_next.prdata[`PWM_PORT_PIN] = st_reg.pin_sync[1];
				end
				`PWM_OFS_STATUS: st_next.prdata[2:0] = {core_run, core_lead, core_level};
				default: st_next.pslverr = 1'b1;
			endcase
		end
		if (access_done && pwrite && !st_reg.pslverr) begin
			case (paddr)
				`PWM_OFS_CTRL: begin
					st_next.ctrl_en = pwdata[`PWM_CTRL_EN];
					st_next.ctrl_src = pwdata[`PWM_CTRL_SRC];
				end
				`PWM_OFS_PRESC: st_next.presc = pwdata[7:0];
				`PWM_OFS_DUTY: st_next.duty = pwdata[7:0];
				`PWM_OFS_PORT: begin
					st_next.port_val = pwdata[`PWM_PORT_VAL];
					st_next.port_dir = pwdata[`PWM_PORT_DIR];
				end
				default: st_next.ctrl_en = st_reg.ctrl_en;
			endcase
		end
		// modulator owns the pin while enabled, else the port bit does
		st_next.pin_o = st_reg.ctrl_en ? core_level : st_reg.port_val;
		st_next.pin_oe = st_reg.ctrl_en | st_reg.port_dir;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= TOP_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign prdata = st_reg.prdata;
	assign shared_port_pin_o = st_reg.pin_o;
	assign shared_port_pin_oe = st_reg.pin_oe;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	property p_pin_follows_pwm;
		@(posedge pclk) disable iff (!presetn)
		st_reg.ctrl_en |=> shared_port_pin_oe && shared_port_pin_o == $past(core_level);
	endproperty
	a_pin_follows_pwm: assert property (p_pin_follows_pwm) else $error("pin not driven by pulse");

	property p_enable_starts;
		@(posedge pclk) disable iff (!presetn)
		$rose(st_reg.ctrl_en) |=> core_lead && !core_level;
	endproperty
	a_enable_starts: assert property (p_enable_starts) else $error("enable did not start lead-in");

endmodule // pwm_prescaled

`default_nettype wire

/* File: testbench/pwm_load_model.sv */
// load model on the shared pulse pin, timing its high and low runs
`timescale 1ns/10ps
`default_nettype none
module pwm_load_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pin
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin_i,
	// run lengths in clocks and edge counts
	output int        hi_len,
	output int        lo_len,
	output int        lead_len,
	output int        rises,
	output int        falls
);
	int   run;
	logic lvl;
	logic oe_d;
	logic seen;
	// pull-down load: a released pin reads low, never the last value
	assign pin_i = pin_oe ? pin_o : 1'b0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run, hi_len, lo_len, lead_len, rises, falls} <= '0;
			{lvl, oe_d, seen} <= '0;
		end else begin
			lvl <= pin_i;
			oe_d <= pin_oe;
			run <= run + 1;
			if (!pin_oe) seen <= 1'b0;
			if (pin_oe && !oe_d) run <= 1;
			if (pin_i && !lvl) begin
				run <= 1;
				rises <= rises + 1;
				lo_len <= run;
				if (!seen) lead_len <= run;
				seen <= 1'b1;
			end
			if (!pin_i && lvl) begin
				run <= 1;
				falls <= falls + 1;
				hi_len <= run;
			end
		end
	end
endmodule // pwm_load_model
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking testbench of the pulse-width modulator
`timescale 1ns/10ps
`default_nettype none
`include "pwm_params.svh"
module testbench;
	logic                   pclk;
	logic                   presetn;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [`PWM_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata;
	logic                   pready;
	logic                   pslverr;
	logic [31:0]            prdata;
	logic                   pin_i;
	logic                   pin_o;
	logic                   pin_oe;
	int                     hi_len, lo_len, lead_len, rises, falls;
	int                     mismatches, n_checks, la, lb;
	logic [31:0]            rd;
	logic                   err;

	pwm_prescaled u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .shared_port_pin_i(pin_i), .shared_port_pin_o(pin_o),
		.shared_port_pin_oe(pin_oe));
	pwm_load_model u_load (.pclk(pclk), .presetn(presetn), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_i(pin_i), .hi_len(hi_len), .lo_len(lo_len), .lead_len(lead_len),
		.rises(rises), .falls(falls));

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	// ----
	// shared tasks
	// ----
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic wr, input logic [`PWM_ADDR_W-1:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) chk("pready", 32'h1, 32'h0);
	endtask
	// bounded wait for k more rising or falling pin edges
	task automatic wait_evt(input logic on_rise, input int k);
		int i, c0;
		c0 = on_rise ? rises : falls;
		i = 0;
		while ((on_rise ? rises : falls) < c0 + k && i < 3000) begin
			@(posedge pclk);
			i++;
		end
		if (i >= 3000) chk("pin edge", 32'h1, 32'h0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		logic [`PWM_ADDR_W-1:0] a[6];
		a = '{`PWM_OFS_CTRL, `PWM_OFS_PRESC, `PWM_OFS_DUTY, `PWM_OFS_PORT, `PWM_OFS_STATUS,
			12'h014};
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, a[i], 32'h0);
			chk("reset read", 32'h0, rd);
			chk("slave error", {31'h0, i == 5}, {31'h0, err});
		end
	endtask
	task automatic t_port;
		xfer(1'b1, `PWM_OFS_PORT, 32'h3);
		repeat (3) @(posedge pclk);
		chk("port drive", 32'h3, {30'h0, pin_oe, pin_o});
		xfer(1'b0, `PWM_OFS_PORT, 32'h0);
		chk("port read", 32'h7, rd);
		xfer(1'b1, `PWM_OFS_PORT, 32'h0);
		repeat (3) @(posedge pclk);
		chk("port released", 32'h0, {30'h0, pin_oe, pin_o});
	endtask
	task automatic t_wave(input logic src, input int n, input int m);
		int f0, cc;
		cc = src ? 2 : 1;
		f0 = falls;
		xfer(1'b1, `PWM_OFS_PRESC, n);
		xfer(1'b1, `PWM_OFS_DUTY, m);
		xfer(1'b1, `PWM_OFS_CTRL, {30'h0, src, 1'b1});
		wait_evt(1'b1, 1);
		chk("first edge rises", f0, falls);
		chk("pin enabled", 32'h1, {31'h0, pin_oe});
		wait_evt(1'b0, 2);
		chk("high run", m * (n + 1) * cc, hi_len);
		chk("low run", (255 - m) * (n + 1) * cc, lo_len);
		xfer(1'b1, `PWM_OFS_CTRL, 32'h0);
		// let a last fall settle before the next scenario counts edges
		repeat (3) @(posedge pclk);
		chk("pin released", 32'h0, {30'h0, pin_oe, pin_o});
	endtask
	task automatic t_lead(input logic src, input int n, output int len);
		xfer(1'b1, `PWM_OFS_PRESC, n);
		xfer(1'b1, `PWM_OFS_DUTY, 32'h1);
		xfer(1'b1, `PWM_OFS_CTRL, {30'h0, src, 1'b1});
		wait_evt(1'b1, 1);
		len = lead_len;
		xfer(1'b1, `PWM_OFS_CTRL, 32'h0);
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_update;
		xfer(1'b1, `PWM_OFS_PRESC, 32'h0);
		xfer(1'b1, `PWM_OFS_DUTY, 32'hA);
		xfer(1'b1, `PWM_OFS_CTRL, 32'h1);
		wait_evt(1'b1, 1);
		xfer(1'b1, `PWM_OFS_DUTY, 32'h14);
		wait_evt(1'b0, 1);
		chk("high kept", 32'hA, hi_len);
		xfer(1'b0, `PWM_OFS_STATUS, 32'h0);
		chk("status running low", 32'h4, rd);
		wait_evt(1'b0, 1);
		chk("low kept", 32'hF5, lo_len);
		chk("high next", 32'h14, hi_len);
		xfer(1'b1, `PWM_OFS_CTRL, 32'h0);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		mismatches = 0;
		n_checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_port;
		t_wave(1'b0, 1, 3);
		t_wave(1'b1, 0, 2);
		t_wave(1'b0, 0, 254);
		t_lead(1'b0, 9, la);
		t_lead(1'b0, 3, lb);
		chk("lead step undivided", 32'h3, la - lb);
		t_lead(1'b1, 4, la);
		t_lead(1'b1, 0, lb);
		chk("lead step divided", 32'h4, la - lb);
		t_update;
		close_out;
	end

	// hang guard, well beyond the two thousand or so clocks the run needs
	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		close_out;
	end
endmodule // testbench
`default_nettype wire
